/* logic/erb_pkg.sv */
`default_nettype none
package erb_pkg;

   // Physical block sizes, parity included, and widest configurations
   localparam int ERB_SMALL_BITS = 576;
   localparam int ERB_SMALL_WMAX = 18;
   localparam int ERB_MEDIUM_BITS = 4608;
   localparam int ERB_MEDIUM_WMAX = 36;
   localparam int ERB_LARGE_BITS = 589824;
   localparam int ERB_LARGE_WMAX = 144;
   localparam int ERB_SPLIT_BITS = 2048;

   // Port shape: 72-bit words in six 12-bit slices, eight 9-bit lanes
   localparam int ERB_PORT_W = 72;
   localparam int ERB_SLICE_W = 12;
   localparam int ERB_SLICES = 6;
   localparam int ERB_ADDR_W = 16;
   localparam int ERB_BE_W = 8;
   localparam int ERB_LANE_W = 9;

   // Register bus map
   localparam int ERB_AXI_AW = 12;
   localparam logic [11:0] ERB_CTRL_OFS = 12'h000;
   localparam logic [11:0] ERB_STAT_OFS = 12'h004;
   localparam int ERB_CTRL_MODE_LSB = 0;
   localparam int ERB_CTRL_OREG_A = 2;
   localparam int ERB_CTRL_OREG_B = 3;
   localparam int ERB_CTRL_FLOW = 4;
   localparam int ERB_STAT_COLL = 0;
   localparam int ERB_STAT_MODE_LSB = 1;
   localparam logic [7:0] ERB_CTRL_RST = 8'h02;
   localparam logic [1:0] ERB_RESP_OKAY = 2'h0;
   localparam logic [1:0] ERB_RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {ERB_SINGLE, ERB_SIMPLE, ERB_TRUE, ERB_SPLIT} erb_mode_t;
   typedef enum logic [1:0] {ERB_SMALL, ERB_MEDIUM, ERB_LARGE} erb_size_t;

   // One port request as driven by fabric logic
   typedef struct packed {
      logic clken;
      logic renwe;
      logic [ERB_BE_W-1:0] be;
      logic [ERB_ADDR_W-1:0] addr;
      logic [ERB_PORT_W-1:0] din;
   } erb_req_t;

   // Words held by a block of a given size at a given width
   function automatic int erb_depth(erb_size_t s, int w);
      case (s)
         ERB_SMALL: return ERB_SMALL_BITS / w;
         ERB_MEDIUM: return ERB_MEDIUM_BITS / w;
         default: return ERB_LARGE_BITS / w;
      endcase
   endfunction

endpackage
`default_nettype wire

/* logic/erb_port.sv */
`timescale 1ns/1ps
`default_nettype none
module erb_port
   import erb_pkg::*;
#(
   parameter int W = ERB_PORT_W
) (
   // Clock and resets
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic aclr_in,
   input wire logic aclr_out,
   // Fabric request and configuration
   input wire erb_req_t req,
   input wire logic oreg_en,
   input wire logic flow_en,
   // Array side
   input wire logic [W-1:0] rd_word,
   input wire logic [W-1:0] flow_word,
   output erb_req_t req_q,
   output logic wr_strobe,
   // Read data
   output logic [W-1:0] dout
);

   erb_req_t req_d;
   logic [W-1:0] rd_q, rd_d, out_q, out_d;

   // Input capture on clock enable
   always_comb begin
      req_d = req_q;
      req_d.clken = req.clken; // Enable marks one edge only, no repeated strobe
      if (req.clken) begin
         req_d = req;
      end
   end

   // Input registers, cleared at once by their own clear
   always_ff @(posedge clk_sys or negedge rstn or posedge aclr_in) begin
      if (!rstn || aclr_in) begin
         req_q <= '0;
      end else begin
         req_q <= req_d;
      end
   end

   // Self-timed strobe from registered controls
   assign wr_strobe = req_q.clken & req_q.renwe;

   // Array read stage, loads only on a registered read
   always_comb begin
      rd_d = rd_q;
      if (req_q.clken && !req_q.renwe) begin
         rd_d = rd_word;
      end
      out_d = rd_q;
   end

   // Array latch; an input clear shows here only after an edge
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rd_q <= '0;
      end else begin
         rd_q <= rd_d;
      end
   end

   // Optional output register with immediate clear
   always_ff @(posedge clk_sys or negedge rstn or posedge aclr_out) begin
      if (!rstn || aclr_out) begin
         out_q <= '0;
      end else begin
         out_q <= out_d;
      end
   end

   // Output select: flow-through, registered or bypassed
   assign dout = flow_en ? flow_word : (oreg_en ? out_q : rd_q);

   a_out_clear: assert property (@(posedge clk_sys) disable iff (!rstn)
      (aclr_out && oreg_en && !flow_en) |-> dout == '0)
      else $error("output clear not seen on read data");

   a_in_clear: assert property (@(posedge clk_sys) disable iff (!rstn)
      $rose(aclr_in) |-> (req_q == '0) && (rd_q == $past(rd_q)))
      else $error("input clear reached read data before an edge");

   a_oreg_pipe: assert property (@(posedge clk_sys) disable iff (!rstn)
      (oreg_en && !flow_en && !aclr_out && $past(!aclr_out)) |-> dout == $past(rd_q))
      else $error("output register not one stage behind array");

endmodule
`default_nettype wire

/* logic/erb_top.sv */
// Operation
// - Small block: 576 bits, at most 18 wide
// - Medium block: 4,608 bits, true dual, 36 wide
// - Large block: 589,824 bits, true dual, 144 wide
// - Port inputs captured in input registers, except the port B address on a flow-through read
// - Write strobe generated internally from port clock
// - Output registers optional, else array data direct
// - Flow-through read in simple dual, small/medium
// - Medium block splits into two half singles
// - Input clear immediate, output follows next edge
// - Output clear immediate on registered read data
// - One extra bit stored per data byte
// - Byte enables mask writes, medium and large
// - 72-bit data per port, six 12-bit slices
// - Shallow memories share address across parallel slices
// - Single port: one address, no simultaneous access; port B still reads at its own address, only its writes are blocked
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module erb_top
   import erb_pkg::*;
#(
   parameter erb_size_t BLOCK = ERB_LARGE,
   parameter int W = ERB_PORT_W
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // Register bus write channels
   input wire logic [ERB_AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // Register bus read channels
   input wire logic [ERB_AXI_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Port A
   input wire erb_req_t req_a,
   input wire logic aclr_in_a,
   input wire logic aclr_out_a,
   output logic [W-1:0] dout_a,
   // Port B
   input wire erb_req_t req_b,
   input wire logic aclr_in_b,
   input wire logic aclr_out_b,
   output logic [W-1:0] dout_b
);

   // Array geometry follows block size at the port width
   localparam int DEPTH = erb_depth(BLOCK, W);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int LANES = W / ERB_LANE_W;
   localparam int WMAX = (BLOCK == ERB_SMALL) ? ERB_SMALL_WMAX :
                         (BLOCK == ERB_MEDIUM) ? ERB_MEDIUM_WMAX : ERB_LARGE_WMAX;
   localparam int SPLIT_DEPTH = ERB_SPLIT_BITS / W;

   // Bus-side state
   logic aw_ok_q, aw_ok_d, w_ok_q, w_ok_d, bvalid_q, bvalid_d, rvalid_q, rvalid_d;
   logic [ERB_AXI_AW-1:0] aw_addr_q, aw_addr_d;
   logic [31:0] w_data_q, w_data_d, rdata_q, rdata_d;
   logic [3:0] w_strb_q, w_strb_d;
   logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
   logic [7:0] ctrl_q, ctrl_d;
   logic coll_q, coll_d;
   logic wr_go;
   logic [11:0] wr_ofs, rd_ofs;

   // Datapath signals
   erb_mode_t mode;
   logic oreg_a, oreg_b, flow;
   erb_req_t qa, qb;
   logic stb_a, stb_b, wstb_a, wstb_b, collide;
   logic [AW-1:0] idx_a, idx_b, fidx_b;
   logic [W-1:0] mem_q [DEPTH];
   logic [W-1:0] rword_a, rword_b, fword_b;
   logic [ERB_BE_W-1:0] be_a, be_b;

   // Effective mode: the small block has no true dual port and no split
   always_comb begin
      mode = erb_mode_t'(ctrl_q[ERB_CTRL_MODE_LSB +: 2]);
      if (BLOCK == ERB_SMALL && (mode == ERB_TRUE || mode == ERB_SPLIT)) begin
         mode = ERB_SIMPLE;
      end
      if (BLOCK == ERB_LARGE && mode == ERB_SPLIT) begin
         mode = ERB_TRUE;
      end
      oreg_a = ctrl_q[ERB_CTRL_OREG_A];
      oreg_b = ctrl_q[ERB_CTRL_OREG_B];
      flow = ctrl_q[ERB_CTRL_FLOW] && mode == ERB_SIMPLE && BLOCK != ERB_LARGE;
   end

   // Register bus: write address and data in either order
   assign s_axi_awready = !aw_ok_q && !bvalid_q;
   assign s_axi_wready = !w_ok_q && !bvalid_q;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   assign wr_ofs = {aw_addr_q[11:2], 2'h0};
   assign rd_ofs = {s_axi_araddr[11:2], 2'h0};
   assign wr_go = aw_ok_q && w_ok_q;

   // Bus next state, control and sticky collision flag
   always_comb begin
      aw_ok_d = aw_ok_q;
      aw_addr_d = aw_addr_q;
      w_ok_d = w_ok_q;
      w_data_d = w_data_q;
      w_strb_d = w_strb_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      rvalid_d = rvalid_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      ctrl_d = ctrl_q;
      coll_d = coll_q;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_ok_d = 1'b1;
         aw_addr_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_ok_d = 1'b1;
         w_data_d = s_axi_wdata;
         w_strb_d = s_axi_wstrb;
      end
      if (wr_go) begin
         aw_ok_d = 1'b0;
         w_ok_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = ERB_RESP_OKAY;
         if (wr_ofs == ERB_CTRL_OFS) begin
            if (w_strb_q[0]) begin
               ctrl_d = w_data_q[7:0];
            end
         end else if (wr_ofs == ERB_STAT_OFS) begin
            if (w_strb_q[0] && w_data_q[ERB_STAT_COLL]) begin
               coll_d = 1'b0;
            end
         end else begin
            bresp_d = ERB_RESP_SLVERR;
         end
      end
      if (bvalid_q && s_axi_bready) begin
         bvalid_d = 1'b0;
      end
      if (collide) begin
         coll_d = 1'b1; // Set wins over a clear in the same cycle
      end
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_d = 1'b1;
         rresp_d = ERB_RESP_OKAY;
         rdata_d = '0;
         if (rd_ofs == ERB_CTRL_OFS) begin
            rdata_d[7:0] = ctrl_q;
         end else if (rd_ofs == ERB_STAT_OFS) begin
            rdata_d[ERB_STAT_COLL] = coll_q;
            rdata_d[ERB_STAT_MODE_LSB +: 2] = mode;
         end else begin
            rresp_d = ERB_RESP_SLVERR;
         end
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_d = 1'b0;
      end
   end

   // Bus registers
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         aw_ok_q <= 1'b0;
         aw_addr_q <= '0;
         w_ok_q <= 1'b0;
         w_data_q <= '0;
         w_strb_q <= '0;
         bvalid_q <= 1'b0;
         bresp_q <= ERB_RESP_OKAY;
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= ERB_RESP_OKAY;
         ctrl_q <= ERB_CTRL_RST;
         coll_q <= 1'b0;
      end else begin
         aw_ok_q <= aw_ok_d;
         aw_addr_q <= aw_addr_d;
         w_ok_q <= w_ok_d;
         w_data_q <= w_data_d;
         w_strb_q <= w_strb_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         rvalid_q <= rvalid_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
         ctrl_q <= ctrl_d;
         coll_q <= coll_d;
      end
   end

   // Port front ends
   erb_port #(.W(W)) u_port_a (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .aclr_in(aclr_in_a),
      .aclr_out(aclr_out_a),
      .req(req_a),
      .oreg_en(oreg_a),
      .flow_en(1'b0),
      .rd_word(rword_a),
      .flow_word(rword_a),
      .req_q(qa),
      .wr_strobe(stb_a),
      .dout(dout_a)
   );

   erb_port #(.W(W)) u_port_b (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .aclr_in(aclr_in_b),
      .aclr_out(aclr_out_b),
      .req(req_b),
      .oreg_en(oreg_b),
      .flow_en(flow),
      .rd_word(rword_b),
      .flow_word(fword_b),
      .req_q(qb),
      .wr_strobe(stb_b),
      .dout(dout_b)
   );

   // Address mapping per mode; split keeps each half to itself
   always_comb begin
      idx_a = qa.addr[AW-1:0];
      idx_b = qb.addr[AW-1:0];
      fidx_b = req_b.addr[AW-1:0]; // Flow-through address bypasses its register
      if (mode == ERB_SPLIT) begin
         idx_a[AW-1] = 1'b0;
         idx_b[AW-1] = 1'b1;
      end
   end

   // Write permission per mode
   assign wstb_a = stb_a;
   assign wstb_b = stb_b && (mode == ERB_TRUE || mode == ERB_SPLIT);
   assign collide = wstb_a && wstb_b && idx_a == idx_b;

   // Byte enables exist on the medium and large blocks only
   assign be_a = (BLOCK == ERB_SMALL) ? '1 : qa.be;
   assign be_b = (BLOCK == ERB_SMALL) ? '1 : qb.be;

   // Array reads; all slices share one address
   assign rword_a = mem_q[idx_a];
   assign rword_b = mem_q[idx_b];
   assign fword_b = mem_q[fidx_b];

   // Array writes; each 9-bit lane carries a byte and its parity bit
   always_ff @(posedge clk_sys) begin
      for (int l = 0; l < LANES; l++) begin
         if (wstb_a && be_a[l]) begin
            mem_q[idx_a][l*ERB_LANE_W +: ERB_LANE_W] <= qa.din[l*ERB_LANE_W +: ERB_LANE_W];
         end
         if (wstb_b && be_b[l]) begin
            mem_q[idx_b][l*ERB_LANE_W +: ERB_LANE_W] <= qb.din[l*ERB_LANE_W +: ERB_LANE_W];
         end
      end
   end

   // Helper views of lane 0 for the checks below
   logic [ERB_LANE_W-1:0] lane0_a;
   assign lane0_a = rword_a[ERB_LANE_W-1:0];

   a_geom_fits: assert property (@(posedge clk_sys) disable iff (!rstn)
      DEPTH * W == ((BLOCK == ERB_SMALL) ? ERB_SMALL_BITS :
                    (BLOCK == ERB_MEDIUM) ? ERB_MEDIUM_BITS : ERB_LARGE_BITS)
      && (BLOCK != ERB_SMALL || mode != ERB_TRUE) && WMAX >= ERB_SMALL_WMAX)
      else $error("array size or mode does not match block");

   a_input_capture: assert property (@(posedge clk_sys) disable iff (!rstn)
      (req_a.clken && !aclr_in_a) ##1 !aclr_in_a |->
      (qa.addr == $past(req_a.addr)) && (qa.din == $past(req_a.din)))
      else $error("port input not registered");

   a_strobe_gen: assert property (@(posedge clk_sys) disable iff (!rstn)
      (req_a.clken && req_a.renwe && !aclr_in_a) ##1 !aclr_in_a |->
      wstb_a ##1 (!wstb_a || $past(req_a.clken)))
      else $error("internal write strobe missing");

   a_lane_write: assert property (@(posedge clk_sys) disable iff (!rstn)
      (wstb_a && be_a[0] && !(wstb_b && idx_b == idx_a)) |=> $past(qa.din[ERB_LANE_W-1:0]) == mem_q[$past(idx_a)][ERB_LANE_W-1:0])
      else $error("enabled lane not written");

   a_lane_mask: assert property (@(posedge clk_sys) disable iff (!rstn)
      (wstb_a && !be_a[0] && !wstb_b && !req_a.clken) |=> lane0_a == $past(lane0_a))
      else $error("masked lane was changed");

   a_single_port: assert property (@(posedge clk_sys) disable iff (!rstn)
      (mode == ERB_SINGLE || mode == ERB_SIMPLE) |-> !wstb_b)
      else $error("port B wrote outside dual-port modes");

   a_split_half: assert property (@(posedge clk_sys) disable iff (!rstn)
      (mode == ERB_SPLIT) |-> !idx_a[AW-1] && idx_b[AW-1] && SPLIT_DEPTH * 2 <= DEPTH)
      else $error("split halves overlap");

   a_read_latency: assert property (@(posedge clk_sys) disable iff (!rstn)
      (req_a.clken && !req_a.renwe && !oreg_a && !wstb_b && !aclr_in_a && !wstb_a)
      ##1 (!aclr_in_a && !wstb_b) |=> dout_a == $past(rword_a))
      else $error("read data not two edges after request");

   a_flow_read: assert property (@(posedge clk_sys) disable iff (!rstn)
      flow |-> dout_b == mem_q[req_b.addr[AW-1:0]])
      else $error("flow-through read not same cycle");

endmodule
`default_nettype wire

/* verif/erb_fabric.sv */
`timescale 1ns/1ps
`default_nettype none
module erb_fabric
   import erb_pkg::*;
(
   // Request towards one port of the block
   output erb_req_t req
);
   // Enable, select, lanes with spare bit, address, data
   task automatic put(logic en, logic we, logic [7:0] be, logic [15:0] a, logic [71:0] d);
      req <= '{en, we, be, a, d};
   endtask

   // Idle port: unqualified fields scramble rather than hold
   task automatic idle();
      req <= '{1'b0, ~req.renwe, ~req.be, ~req.addr, ~req.din};
   endtask

   initial req = '0;
endmodule
`default_nettype wire

/* verif/tb_dual_port_embedded_ram.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_dual_port_embedded_ram
   import erb_pkg::*;
();
   localparam int DEPTH = ERB_MEDIUM_BITS / ERB_PORT_W;
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   logic [11:0] s_axi_awaddr = '0;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_awready;
   logic [31:0] s_axi_wdata = '0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_wready;
   logic [1:0] s_axi_bresp;
   logic s_axi_bvalid;
   logic s_axi_bready = 1'b0;
   logic [11:0] s_axi_araddr = '0;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0] s_axi_rresp;
   logic s_axi_rvalid;
   logic s_axi_rready = 1'b0;
   erb_req_t req_a;
   erb_req_t req_b;
   logic aclr_in_a = 1'b0;
   logic aclr_out_a = 1'b0;
   logic aclr_in_b = 1'b0;
   logic aclr_out_b = 1'b0;
   logic [71:0] dout_a;
   logic [71:0] dout_b;
   // Reference model state
   logic [71:0] mem_m [DEPTH];
   logic [71:0] last_m [2];
   logic [1:0] mode_m = 2'd2;
   logic [1:0] oreg_m = 2'b00;
   int seed = 12;
   int n_fail = 0;
   int check_count = 0;

   always #5 clk_sys = ~clk_sys;

   // Block under test, fabric models on both ports
   erb_top #(.BLOCK(ERB_MEDIUM), .W(ERB_PORT_W)) u_erb_top (
      .clk_sys, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .req_a, .aclr_in_a, .aclr_out_a,
      .dout_a, .req_b, .aclr_in_b, .aclr_out_b, .dout_b
   );
   erb_fabric u_fab_a (.req(req_a));
   erb_fabric u_fab_b (.req(req_b));

   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(logic [71:0] got, logic [71:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic stall();
      n_fail++;
      $display("ERROR at %0t: bus answer never came", $time);
      summarize();
   endtask

   function automatic logic [71:0] rnd72();
      logic [95:0] r;
      r = {$random(seed), $random(seed), $random(seed)};
      return r[71:0];
   endfunction

   // Word index as the model sees it; split halves the array per port
   function automatic int idx(bit p, logic [15:0] a);
      if (mode_m == 2'd3) return p * (DEPTH / 2) + a % (DEPTH / 2);
      return a % DEPTH;
   endfunction

   function automatic logic [71:0] merge(logic [71:0] o, logic [71:0] n, logic [7:0] be);
      for (int l = 0; l < 8; l++) begin
         if (be[l]) o[9*l +: 9] = n[9*l +: 9];
      end
      return o;
   endfunction

   task automatic put(bit p, logic en, logic we, logic [7:0] be, logic [15:0] a, logic [71:0] d);
      if (p) u_fab_b.put(en, we, be, a, d);
      else u_fab_a.put(en, we, be, a, d);
   endtask

   task automatic idle(bit p);
      if (p) u_fab_b.idle();
      else u_fab_a.idle();
   endtask

   // One write; model takes it only where the mode lets that port write
   task automatic wr(bit p, bit en, logic [7:0] be, logic [15:0] a, logic [71:0] d);
      int i = idx(p, a);
      @(posedge clk_sys);
      put(p, en, 1'b1, be, a, d);
      @(posedge clk_sys);
      idle(p);
      @(posedge clk_sys);
      if (en && (!p || mode_m[1])) mem_m[i] = merge(mem_m[i], d, be);
   endtask

   // One read, checked at the exact edge for the output register setting
   task automatic rd(bit p, logic [15:0] a);
      logic [71:0] e = mem_m[idx(p, a)];
      @(posedge clk_sys);
      put(p, 1'b1, 1'b0, 8'h00, a, rnd72());
      @(posedge clk_sys);
      idle(p);
      @(posedge clk_sys);
      #1;
      if (oreg_m[p]) begin
         chk(p ? dout_b : dout_a, last_m[p]);
         @(posedge clk_sys);
         #1;
      end
      chk(p ? dout_b : dout_a, e);
      last_m[p] = e;
   endtask

   task automatic axi_wr(logic [11:0] a, logic [31:0] v, output logic [1:0] r);
      bit aw;
      bit w;
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= v;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (int i = 0; i < 50; i++) begin
         #1;
         aw = s_axi_awvalid && s_axi_awready;
         w = s_axi_wvalid && s_axi_wready;
         r = s_axi_bresp;
         if (s_axi_bvalid) begin
            @(posedge clk_sys);
            s_axi_bready <= 1'b0;
            return;
         end
         @(posedge clk_sys);
         if (aw) s_axi_awvalid <= 1'b0;
         if (w) s_axi_wvalid <= 1'b0;
      end
      stall();
   endtask

   task automatic axi_rd(logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      bit ar;
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (int i = 0; i < 50; i++) begin
         #1;
         ar = s_axi_arvalid && s_axi_arready;
         d = s_axi_rdata;
         r = s_axi_rresp;
         if (s_axi_rvalid) begin
            @(posedge clk_sys);
            s_axi_rready <= 1'b0;
            return;
         end
         @(posedge clk_sys);
         if (ar) s_axi_arvalid <= 1'b0;
      end
      stall();
   endtask

   // Program mode and output registers, read both registers back
   task automatic set_ctrl(logic [7:0] v);
      logic [31:0] d;
      logic [1:0] r;
      axi_wr(ERB_CTRL_OFS, 32'(v), r);
      chk(72'(r), 72'(ERB_RESP_OKAY));
      axi_rd(ERB_CTRL_OFS, d, r);
      chk(72'(d[7:0]), 72'(v));
      axi_rd(ERB_STAT_OFS, d, r);
      chk(72'(d[2:1]), 72'(v[1:0]));
      mode_m = v[1:0];
      oreg_m = v[3:2];
   endtask

   task automatic done(string s);
      $display("test %s done", s);
   endtask

   initial begin
      logic [31:0] d;
      logic [1:0] r;
      last_m[0] = '0;
      last_m[1] = '0;
      repeat (16) @(posedge clk_sys);
      rstn <= 1'b1;
      // Register defaults and unmapped offsets
      axi_rd(ERB_CTRL_OFS, d, r);
      chk(72'(d), 72'(ERB_CTRL_RST));
      axi_rd(12'h008, d, r);
      chk(72'(r), 72'(ERB_RESP_SLVERR));
      axi_wr(12'h00c, 32'hffff_ffff, r);
      chk(72'(r), 72'(ERB_RESP_SLVERR));
      done("registers");
      // Fill, then random lanes on both ports, never one address twice per cycle
      for (int i = 0; i < DEPTH; i++) wr(1'b0, 1'b1, 8'hff, 16'(i), rnd72());
      for (int i = 0; i < 24; i++) begin
         wr(1'($random(seed)), 1'b1, 8'($random(seed)), 16'($random(seed)), rnd72());
         rd(1'($random(seed)), 16'($random(seed)));
      end
      done("true dual");
      // Select high without clock enable must not write
      wr(1'b0, 1'b0, 8'hff, 16'h3, rnd72());
      rd(1'b0, 16'h3);
      done("clock enable");
      // Output registers on, then clear port A's between edges
      set_ctrl(8'h0e);
      for (int i = 0; i < 4; i++) rd(1'(i), 16'($random(seed)));
      #2 aclr_out_a = 1'b1;
      #1 chk(dout_a, '0);
      // Clear held across an edge keeps the register at zero
      @(posedge clk_sys);
      #1 chk(dout_a, '0);
      #1 aclr_out_a = 1'b0;
      done("output registers");
      // Input clear after capture squashes the write
      set_ctrl(8'h02);
      @(posedge clk_sys);
      put(1'b0, 1'b1, 1'b1, 8'hff, 16'h9, rnd72());
      @(posedge clk_sys);
      idle(1'b0);
      #2 aclr_in_a = 1'b1;
      #1 chk(dout_a, last_m[0]);
      // Clear held across an edge: no write lands, read data unchanged
      @(posedge clk_sys);
      #1 chk(dout_a, last_m[0]);
      #1 aclr_in_a = 1'b0;
      rd(1'b0, 16'h9);
      done("input clear");
      // Single port: second port writes refused
      set_ctrl(8'h00);
      wr(1'b1, 1'b1, 8'hff, 16'h7, rnd72());
      rd(1'b0, 16'h7);
      done("single port");
      // Simple dual with flow-through read on the second port
      set_ctrl(8'h11);
      wr(1'b0, 1'b1, 8'h0f, 16'h4, rnd72());
      @(posedge clk_sys);
      put(1'b1, 1'b1, 1'b0, 8'h00, 16'h4, rnd72());
      #1 chk(dout_b, mem_m[4]);
      @(posedge clk_sys);
      idle(1'b1);
      done("flow through");
      // Split: same address lands in separate halves per port
      set_ctrl(8'h03);
      wr(1'b0, 1'b1, 8'hff, 16'h5, rnd72());
      wr(1'b1, 1'b1, 8'hff, 16'h5, rnd72());
      rd(1'b0, 16'h5);
      rd(1'b1, 16'h5);
      done("split");
      summarize();
   end
endmodule
`default_nettype wire
